// file: hsq_regs.svh
// Register offsets, field positions, reset values and timing for the sequencer
`ifndef HSQ_REGS_SVH
`define HSQ_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define HSQ_ADDR_TEMP_RES 8'hd7
`define HSQ_ADDR_START 8'hd8
`define HSQ_ADDR_BATT_RES 8'hdf
`define HSQ_ADDR_IRQ_EN 8'hec
`define HSQ_ADDR_EXT_RES 8'hef
`define HSQ_ADDR_DELTA 8'hf3
`define HSQ_ADDR_IRQ_FLAG 8'hf8
`define HSQ_ADDR_STROBE 8'hf9
`define HSQ_ADDR_THRESH 8'hfa

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define HSQ_LB_BIT 2
`define HSQ_EV_BIT 3
`define HSQ_TPER_LSB 0
`define HSQ_BPER_LSB 2
`define HSQ_EPER_LSB 4
`define HSQ_EDIFF_LSB 0
`define HSQ_TDIFF_LSB 3
`define HSQ_DELTA_OFF 3'h0
`define HSQ_DELTA_ALL 3'h7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define HSQ_RST_BYTE 8'h00
`define HSQ_RST_GO 3'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define HSQ_CLK_KHZ 50000
`define HSQ_TICK_MS 1000
`define HSQ_TPER1_S 10'h1e0
`define HSQ_TPER2_S 10'h078
`define HSQ_TPER3_S 10'h03c
`define HSQ_BPER2_S 10'h0f0
`define HSQ_BPER3_S 10'h03c

`endif

// file: hsq_pkg.sv
// Types shared by the housekeeping converter sequencer
package hsq_pkg;

  typedef enum logic [1:0] {
    HSQ_IDLE = 2'b01,
    HSQ_WAIT = 2'b10
  } hsq_fsm_t;

  typedef enum logic [1:0] {
    HSQ_CH_BATT = 2'b00,
    HSQ_CH_TEMP = 2'b01,
    HSQ_CH_EXT = 2'b10
  } hsq_chan_t;

  typedef enum logic [1:0] {
    HSQ_PSM_FULL = 2'b00,
    HSQ_PSM_BATT = 2'b01,
    HSQ_PSM_SLEEP = 2'b10
  } hsq_psm_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic due;
  } hsq_ivl_t;

  typedef struct packed {
    hsq_fsm_t fsm;
    logic [2:0] go;
    logic [2:0] bg;
    hsq_chan_t sel;
    logic single;
    logic [7:0] strobe;
    logic [7:0] delta;
    logic [7:0] thresh;
    logic [7:0] irq_en;
    logic flag_lb;
    logic flag_ev;
    logic [7:0] temp_res;
    logic [7:0] batt_res;
    logic [7:0] ext_res;
    logic [7:0] rdata;
    logic conv_req;
    logic temp_irq;
    logic batt_irq;
    logic ext_irq;
    logic psm_irq;
    logic [31:0] pre_cnt;
  } hsq_core_t;

endpackage : hsq_pkg

// file: hsq_interval.sv
// Background interval timer counting one-second ticks
`timescale 1ns/1ps
module hsq_interval #(
  parameter logic [9:0] PER1_S = 10'h1e0,
  parameter logic [9:0] PER2_S = 10'h078,
  parameter logic [9:0] PER3_S = 10'h03c
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [1:0] code,
  output logic due
);

  hsq_pkg::hsq_ivl_t s_ff;
  hsq_pkg::hsq_ivl_t nxt_s;
  logic [9:0] period;

  always_comb begin
    case (code)
      2'h1: period = PER1_S;
      2'h2: period = PER2_S;
      default: period = PER3_S;
    endcase
  end

  // Code zero parks the timer so a later start always waits a full period
  always_comb begin
    nxt_s = s_ff;
    nxt_s.due = 1'b0;
    if (code == 2'h0) begin
      nxt_s.cnt = 10'h000;
    end else if (tick) begin
      if (s_ff.cnt + 10'h001 >= period) begin
        nxt_s.cnt = 10'h000;
        nxt_s.due = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign due = s_ff.due;

endmodule : hsq_interval

// file: hsq_top.sv
// Housekeeping converter sequencer with its special function registers
//
// Behaviour
// - Temperature result is an 8-bit code, 0.83 degC per step.
// - Temperature go bit runs one conversion, then interrupts with result.
// - Background temperature is off from reset until interval is nonzero.
// - Background temperature interrupts only if change from last exceeds delta.
// - Temperature result loads only when temperature interrupt fires.
// - Full-power mode allows background and single conversions for both.
// - Battery-active mode allows single temperature only, no background.
// - Sleep mode allows temperature only from background intervals.
// - Temperature interrupt has no readable or clearable flag.
// - Battery result is an 8-bit code, 14.6 mV per step.
// - Battery go bit runs one conversion, then interrupts with result.
// - Background battery repeats at the battery interval field rate.
// - Low-battery flag sets when a battery code is below threshold.
// - Power interrupt from low-battery flag only when its enable is set.
// - A finished single battery conversion always sets low-battery flag.
// - Battery result loads only when low-battery flag is set.
// - Battery-active mode allows single battery only, no background.
// - Sleep mode performs no battery conversions at all.
// - External voltage result is read-only, resets zero, loads on interrupt.
// - Each go bit clears itself once the request is issued.
// - Delta code 000 disables, 111 hits every conversion, else threshold.
`timescale 1ns/1ps
`include "hsq_regs.svh"
module hsq_top #(
  parameter int TICK_CYCLES = `HSQ_TICK_MS * `HSQ_CLK_KHZ,
  parameter logic [9:0] BPER1_S = 10'h1e0,
  parameter logic [9:0] EPER1_S = 10'h1e0,
  parameter logic [9:0] EPER2_S = 10'h078,
  parameter logic [9:0] EPER3_S = 10'h03c
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] psm_mode,
  output logic conv_req,
  output logic [1:0] conv_sel,
  input wire logic conv_done,
  input wire logic [7:0] conv_data,
  output logic temp_irq,
  output logic batt_irq,
  output logic ext_irq,
  output logic psm_irq
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic hsq_delta_hit(input logic [7:0] nw,
                                         input logic [7:0] last,
                                         input logic [2:0] code);
    logic [7:0] diff;
    diff = (nw > last) ? nw - last : last - nw;
    if (code == `HSQ_DELTA_OFF) begin
      return 1'b0;
    end else if (code == `HSQ_DELTA_ALL) begin
      return 1'b1;
    end
    return diff > {5'h00, code};
  endfunction : hsq_delta_hit

  function automatic logic [1:0] hsq_first(input logic [2:0] v);
    if (v[0]) begin
      return 2'h0;
    end else if (v[1]) begin
      return 2'h1;
    end
    return 2'h2;
  endfunction : hsq_first

  // ------------------------------------------------------------
  // State and interval timers
  // ------------------------------------------------------------
  hsq_pkg::hsq_core_t s_ff;
  hsq_pkg::hsq_core_t nxt_s;
  logic tick;
  logic [2:0] due;
  logic [2:0] single_ok;
  logic [2:0] bg_ok;
  logic [2:0] s_el;
  logic [2:0] b_el;
  logic [1:0] pick;
  logic in_full;
  logic in_sleep;

  // A one-second prescaler keeps the minute-long periods in small counters
  assign tick = (s_ff.pre_cnt == 32'(TICK_CYCLES - 1));

  hsq_interval #(
    .PER1_S(BPER1_S),
    .PER2_S(`HSQ_BPER2_S),
    .PER3_S(`HSQ_BPER3_S)
  ) u_batt_ivl (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .code(s_ff.strobe[`HSQ_BPER_LSB +: 2]),
    .due(due[0])
  );

  hsq_interval #(
    .PER1_S(`HSQ_TPER1_S),
    .PER2_S(`HSQ_TPER2_S),
    .PER3_S(`HSQ_TPER3_S)
  ) u_temp_ivl (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .code(s_ff.strobe[`HSQ_TPER_LSB +: 2]),
    .due(due[1])
  );

  hsq_interval #(
    .PER1_S(EPER1_S),
    .PER2_S(EPER2_S),
    .PER3_S(EPER3_S)
  ) u_ext_ivl (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .code(s_ff.strobe[`HSQ_EPER_LSB +: 2]),
    .due(due[2])
  );

  // ------------------------------------------------------------
  // Power mode gating
  // ------------------------------------------------------------
  always_comb begin
    in_full = (psm_mode == hsq_pkg::HSQ_PSM_FULL);
    in_sleep = (psm_mode == hsq_pkg::HSQ_PSM_SLEEP);
    // Singles need a running core; battery never converts in sleep
    single_ok = in_sleep ? 3'h0 : 3'h7;
    bg_ok[0] = in_full;
    bg_ok[1] = in_full | in_sleep;
    bg_ok[2] = in_full | in_sleep;
    s_el = s_ff.go & single_ok;
    b_el = s_ff.bg & bg_ok;
    pick = (|s_el) ? hsq_first(s_el) : hsq_first(b_el);
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.conv_req = 1'b0;
    nxt_s.temp_irq = 1'b0;
    nxt_s.batt_irq = 1'b0;
    nxt_s.ext_irq = 1'b0;
    nxt_s.pre_cnt = tick ? 32'h0000_0000 : s_ff.pre_cnt + 32'h0000_0001;

    // Issue at most one request and wait for it to finish
    if (s_ff.fsm == hsq_pkg::HSQ_IDLE && |(s_el | b_el)) begin
      nxt_s.conv_req = 1'b1;
      nxt_s.sel = hsq_pkg::hsq_chan_t'(pick);
      nxt_s.single = |s_el;
      nxt_s.fsm = hsq_pkg::HSQ_WAIT;
      if (|s_el) begin
        nxt_s.go[pick] = 1'b0;
      end else begin
        nxt_s.bg[pick] = 1'b0;
      end
    end

    // Register writes; writing zero to a flag clears it
    if (sfr_wr_en) begin
      case (sfr_addr)
        `HSQ_ADDR_START: nxt_s.go = nxt_s.go | sfr_wdata[2:0];
        `HSQ_ADDR_STROBE: nxt_s.strobe = sfr_wdata;
        `HSQ_ADDR_DELTA: nxt_s.delta = {2'h0, sfr_wdata[5:0]};
        `HSQ_ADDR_THRESH: nxt_s.thresh = sfr_wdata;
        `HSQ_ADDR_IRQ_EN: nxt_s.irq_en = sfr_wdata;
        `HSQ_ADDR_IRQ_FLAG: begin
          nxt_s.flag_lb = s_ff.flag_lb & sfr_wdata[`HSQ_LB_BIT];
          nxt_s.flag_ev = s_ff.flag_ev & sfr_wdata[`HSQ_EV_BIT];
        end
        default: ;
      endcase
    end

    // Completion comes after the clear so a new event wins over it
    if (s_ff.fsm == hsq_pkg::HSQ_WAIT && conv_done) begin
      nxt_s.fsm = hsq_pkg::HSQ_IDLE;
      case (s_ff.sel)
        hsq_pkg::HSQ_CH_TEMP: begin
          // Result register doubles as the last interrupting code
          if (s_ff.single || hsq_delta_hit(conv_data, s_ff.temp_res,
              s_ff.delta[`HSQ_TDIFF_LSB +: 3])) begin
            nxt_s.temp_res = conv_data;
            nxt_s.temp_irq = 1'b1;
          end
        end
        hsq_pkg::HSQ_CH_BATT: begin
          if (s_ff.single || conv_data < s_ff.thresh) begin
            nxt_s.flag_lb = 1'b1;
            nxt_s.batt_res = conv_data;
            nxt_s.batt_irq = 1'b1;
          end
        end
        hsq_pkg::HSQ_CH_EXT: begin
          if (s_ff.single) begin
            nxt_s.ext_res = conv_data;
            nxt_s.ext_irq = 1'b1;
          end else if (hsq_delta_hit(conv_data, s_ff.ext_res,
                       s_ff.delta[`HSQ_EDIFF_LSB +: 3])) begin
            nxt_s.flag_ev = 1'b1;
            nxt_s.ext_res = conv_data;
            nxt_s.ext_irq = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Interval expiry queues a background run, set wins over issue clear
    for (int i = 0; i < 3; i++) begin
      if (due[i] && bg_ok[i]) begin
        nxt_s.bg[i] = 1'b1;
      end
    end

    nxt_s.psm_irq = (nxt_s.flag_lb & nxt_s.irq_en[`HSQ_LB_BIT]) |
                    (nxt_s.flag_ev & nxt_s.irq_en[`HSQ_EV_BIT]);

    // Read data lands one cycle after the address
    case (sfr_addr)
      `HSQ_ADDR_TEMP_RES: nxt_s.rdata = s_ff.temp_res;
      `HSQ_ADDR_BATT_RES: nxt_s.rdata = s_ff.batt_res;
      `HSQ_ADDR_EXT_RES: nxt_s.rdata = s_ff.ext_res;
      `HSQ_ADDR_START: nxt_s.rdata = {5'h00, s_ff.go};
      `HSQ_ADDR_STROBE: nxt_s.rdata = s_ff.strobe;
      `HSQ_ADDR_DELTA: nxt_s.rdata = s_ff.delta;
      `HSQ_ADDR_THRESH: nxt_s.rdata = s_ff.thresh;
      `HSQ_ADDR_IRQ_EN: nxt_s.rdata = s_ff.irq_en;
      `HSQ_ADDR_IRQ_FLAG: nxt_s.rdata = {4'h0, s_ff.flag_ev,
                                         s_ff.flag_lb, 2'h0};
      default: nxt_s.rdata = `HSQ_RST_BYTE;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.fsm <= hsq_pkg::HSQ_IDLE;
      s_ff.go <= `HSQ_RST_GO;
      s_ff.strobe <= `HSQ_RST_BYTE;
      s_ff.temp_res <= `HSQ_RST_BYTE;
      s_ff.batt_res <= `HSQ_RST_BYTE;
      s_ff.ext_res <= `HSQ_RST_BYTE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sfr_rdata = s_ff.rdata;
  assign conv_req = s_ff.conv_req;
  assign conv_sel = s_ff.sel;
  assign temp_irq = s_ff.temp_irq;
  assign batt_irq = s_ff.batt_irq;
  assign ext_irq = s_ff.ext_irq;
  assign psm_irq = s_ff.psm_irq;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_done(hsq_pkg::hsq_chan_t ch, logic sg);
    s_ff.fsm == hsq_pkg::HSQ_WAIT && conv_done && s_ff.sel == ch &&
    s_ff.single == sg;
  endsequence

  a_one_conv: assert property (conv_req |=> s_ff.fsm == hsq_pkg::HSQ_WAIT
    && !conv_req) else $error("request while busy");
  a_temp_single: assert property (s_done(hsq_pkg::HSQ_CH_TEMP, 1'b1)
    |=> temp_irq && s_ff.temp_res == $past(conv_data))
    else $error("single temp gave no irq");
  a_temp_delta_off: assert property (s_done(hsq_pkg::HSQ_CH_TEMP, 1'b0)
    ##0 s_ff.delta[5:3] == 3'h0 |=> !temp_irq)
    else $error("delta off still interrupted");
  a_temp_delta_all: assert property (s_done(hsq_pkg::HSQ_CH_TEMP, 1'b0)
    ##0 s_ff.delta[5:3] == 3'h7 |=> temp_irq)
    else $error("delta all missed irq");
  a_temp_load: assert property ($changed(s_ff.temp_res) |-> temp_irq)
    else $error("temp result moved without irq");
  a_irq_pulse: assert property (temp_irq || batt_irq |=> !temp_irq
    && !batt_irq) else $error("irq longer than a cycle");
  a_batt_single: assert property (s_done(hsq_pkg::HSQ_CH_BATT, 1'b1)
    |=> s_ff.flag_lb && batt_irq)
    else $error("single batt no flag");
  a_batt_low: assert property (s_done(hsq_pkg::HSQ_CH_BATT, 1'b0)
    ##0 conv_data < s_ff.thresh |=> s_ff.flag_lb)
    else $error("low batt flag missed");
  a_batt_load: assert property ($changed(s_ff.batt_res) |-> batt_irq)
    else $error("batt result moved without flag");
  a_sleep_batt: assert property (conv_req && conv_sel == 2'h0 |->
    $past(psm_mode) != hsq_pkg::HSQ_PSM_SLEEP)
    else $error("battery run in sleep");
  a_sleep_single: assert property (conv_req && s_ff.single |->
    $past(psm_mode) != hsq_pkg::HSQ_PSM_SLEEP)
    else $error("single run in sleep");
  a_bg_modes: assert property (conv_req && !s_ff.single |->
    $past(psm_mode) != hsq_pkg::HSQ_PSM_BATT)
    else $error("background in battery mode");
  a_psm_gate: assert property (s_ff.irq_en[3:2] == 2'h0 ##1
    s_ff.irq_en[3:2] == 2'h0 |-> !psm_irq)
    else $error("power irq while disabled");
  a_ext_load: assert property ($changed(s_ff.ext_res) |-> ext_irq)
    else $error("ext result moved without irq");

endmodule : hsq_top

// file: hsq_testbench.sv
// Self-checking testbench for the housekeeping converter sequencer
`timescale 1ns/1ps
`include "hsq_regs.svh"
module testbench;
  // ----------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------
  // One second shrinks to 10 cycles, so a 60 s period is 600 cycles
  localparam int TICKS = 10;
  localparam int LIMIT = 12000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr_en = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [1:0] psm_mode = 2'h0;
  logic conv_req;
  logic [1:0] conv_sel;
  logic conv_done = 1'b0;
  logic [7:0] conv_data = 8'h00;
  logic temp_irq;
  logic batt_irq;
  logic ext_irq;
  logic psm_irq;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n_req = 0;
  int n_temp = 0;
  int n_batt = 0;
  int n_bad = 0;
  int n_ext = 0;
  // Requests already claimed by a scenario; a pulse issued mid-task waits here
  int n_srv = 0;

  always #10 clk = ~clk;

  hsq_top #(.TICK_CYCLES(TICKS)) hsq_top_inst (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .psm_mode(psm_mode),
    .conv_req(conv_req), .conv_sel(conv_sel), .conv_done(conv_done),
    .conv_data(conv_data), .temp_irq(temp_irq), .batt_irq(batt_irq),
    .ext_irq(ext_irq), .psm_irq(psm_irq)
  );

  // ----------------------------------------------------------
  // Event counters and hang guard
  // ----------------------------------------------------------
  // Counting pulses instead of catching them keeps tasks race free
  always @(posedge clk) begin
    cyc++;
    if (conv_req === 1'b1) n_req++;
    if (temp_irq === 1'b1) n_temp++;
    if (batt_irq === 1'b1) n_batt++;
    if (ext_irq === 1'b1) n_ext++;
    if (conv_req === 1'b1 && psm_mode == 2'h2 && conv_sel !== 2'h1) n_bad++;
    if (cyc == LIMIT) begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wr_en <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr_en <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk(exp, sfr_rdata);
  endtask : rdchk

  task automatic wait_req(input logic [1:0] sel, input int maxc);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (n_req == n_srv && k < maxc) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(8'h01, 8'(n_req - n_srv));
    chk({6'h00, sel}, {6'h00, conv_sel});
    n_srv = n_req;
  endtask : wait_req

  // Converter answers after lat cycles, then the pulses get time to land
  task automatic reply(input logic [7:0] d, input int lat);
    repeat (lat) @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_data <= ~d;
    repeat (4) @(posedge clk);
    #1;
  endtask : reply

  task automatic serve(input logic [1:0] sel, input logic [7:0] d, int lat);
    wait_req(sel, 700);
    reply(d, lat);
  endtask : serve

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    int r0;
    rdchk(`HSQ_ADDR_TEMP_RES, 8'h00);
    rdchk(`HSQ_ADDR_BATT_RES, 8'h00);
    wr(`HSQ_ADDR_EXT_RES, 8'h5a);
    rdchk(`HSQ_ADDR_EXT_RES, 8'h00);
    rdchk(8'h00, 8'h00);
    r0 = n_req;
    repeat (700) @(posedge clk);
    #1;
    chk(8'h00, 8'(n_req - r0));
  endtask : t_reset

  task automatic t_temp_single;
    int t0;
    t0 = n_temp;
    wr(`HSQ_ADDR_START, 8'h02);
    wait_req(2'h1, 20);
    rdchk(`HSQ_ADDR_START, 8'h00);
    reply(8'h40, 1);
    chk(8'h01, 8'(n_temp - t0));
    rdchk(`HSQ_ADDR_TEMP_RES, 8'h40);
    rdchk(`HSQ_ADDR_IRQ_FLAG, 8'h00);
  endtask : t_temp_single

  task automatic t_batt_single;
    int b0;
    wr(`HSQ_ADDR_THRESH, 8'h10);
    wr(`HSQ_ADDR_IRQ_EN, 8'h04);
    b0 = n_batt;
    wr(`HSQ_ADDR_START, 8'h01);
    serve(2'h0, 8'h80, 5);
    chk(8'h01, 8'(n_batt - b0));
    rdchk(`HSQ_ADDR_BATT_RES, 8'h80);
    rdchk(`HSQ_ADDR_IRQ_FLAG, 8'h04);
    chk(8'h01, {7'h00, psm_irq});
    wr(`HSQ_ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk(8'h00, {7'h00, psm_irq});
    wr(`HSQ_ADDR_IRQ_FLAG, 8'h00);
    rdchk(`HSQ_ADDR_IRQ_FLAG, 8'h00);
  endtask : t_batt_single

  task automatic t_ext;
    int e0;
    e0 = n_ext;
    wr(`HSQ_ADDR_START, 8'h04);
    serve(2'h2, 8'h77, 1);
    chk(8'h01, 8'(n_ext - e0));
    rdchk(`HSQ_ADDR_EXT_RES, 8'h77);
    rdchk(`HSQ_ADDR_IRQ_FLAG, 8'h00);
  endtask : t_ext

  task automatic t_background;
    int t0;
    int b0;
    int r0;
    wr(`HSQ_ADDR_DELTA, 8'h10);
    wr(`HSQ_ADDR_STROBE, 8'h0f);
    t0 = n_temp;
    b0 = n_batt;
    wait_req(2'h0, 700);
    @(posedge clk);
    #1;
    r0 = n_req;
    repeat (5) @(posedge clk);
    #1;
    chk(8'h00, 8'(n_req - r0));
    reply(8'h20, 1);
    serve(2'h1, 8'h42, 1);
    chk(8'h00, 8'(n_batt - b0));
    chk(8'h00, 8'(n_temp - t0));
    rdchk(`HSQ_ADDR_BATT_RES, 8'h80);
    rdchk(`HSQ_ADDR_TEMP_RES, 8'h40);
    serve(2'h0, 8'h08, 2);
    serve(2'h1, 8'h43, 2);
    chk(8'h01, 8'(n_batt - b0));
    chk(8'h01, 8'(n_temp - t0));
    rdchk(`HSQ_ADDR_BATT_RES, 8'h08);
    rdchk(`HSQ_ADDR_IRQ_FLAG, 8'h04);
    rdchk(`HSQ_ADDR_TEMP_RES, 8'h43);
    wr(`HSQ_ADDR_IRQ_FLAG, 8'h00);
  endtask : t_background

  task automatic t_delta;
    logic [2:0] dc [3] = '{3'h7, 3'h0, 3'h1};
    logic [7:0] dd [3] = '{8'h43, 8'h90, 8'h45};
    logic [7:0] de [3] = '{8'h01, 8'h00, 8'h01};
    logic [7:0] dr [3] = '{8'h43, 8'h43, 8'h45};
    int t0;
    wr(`HSQ_ADDR_STROBE, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(`HSQ_ADDR_DELTA, {2'b00, dc[i], 3'b000});
      t0 = n_temp;
      serve(2'h1, dd[i], 1);
      chk(de[i], 8'(n_temp - t0));
      rdchk(`HSQ_ADDR_TEMP_RES, dr[i]);
    end
  endtask : t_delta

  task automatic t_modes;
    int r0;
    int b0;
    int x0;
    wr(`HSQ_ADDR_STROBE, 8'h0f);
    @(posedge clk);
    psm_mode <= 2'h1;
    r0 = n_req;
    repeat (700) @(posedge clk);
    #1;
    chk(8'h00, 8'(n_req - r0));
    b0 = n_batt;
    wr(`HSQ_ADDR_START, 8'h01);
    serve(2'h0, 8'h30, 1);
    chk(8'h01, 8'(n_batt - b0));
    @(posedge clk);
    psm_mode <= 2'h2;
    x0 = n_bad;
    wr(`HSQ_ADDR_START, 8'h01);
    serve(2'h1, 8'h46, 1);
    serve(2'h1, 8'h47, 1);
    chk(8'h00, 8'(n_bad - x0));
    rdchk(`HSQ_ADDR_START, 8'h01);
  endtask : t_modes

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_temp_single();
    t_batt_single();
    t_ext();
    t_background();
    t_delta();
    t_modes();
    final_report();
  end
endmodule : testbench
